// >>> inc/dma_end_pkg.sv
package dma_end_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // bus and register map
   localparam int          DATA_W      = 32;
   localparam int          ADDR_W      = 32;
   localparam int          CTRL_W      = 10;
   localparam logic [7:0]  SRC_OFF     = 8'h00;
   localparam logic [7:0]  DST_OFF     = 8'h04;
   localparam logic [7:0]  CNT_OFF     = 8'h08;
   localparam logic [7:0]  CTRL_OFF    = 8'h0c;
   localparam logic [7:0]  OPR_OFF     = 8'h40;
   localparam int          DME_BIT     = 0;
   localparam int          NMI_ABORT_FLAG_BIT    = 1;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   ////////////////////////////////////////////////////////////////////////////////
   // channel behaviour
   localparam int          RELOAD_CH   = 2;
   localparam logic [1:0]  RELOAD_LAST = 2'h3;
   localparam logic [1:0]  SIZE_BYTE   = 2'h0;
   localparam logic [1:0]  SIZE_HALF   = 2'h1;
   localparam logic [31:0] STEP_BYTE   = 32'h0000_0001;
   localparam logic [31:0] STEP_HALF   = 32'h0000_0002;
   localparam logic [31:0] STEP_WORD   = 32'h0000_0004;

   // bus cycles from first request sample to the first access, and to the second sample
   localparam int          START_CYC   = 3;
   localparam int          SECOND_CYC  = 2;

   typedef struct packed {
      logic [1:0] size;
      logic       reload;
      logic       ack_wr;
      logic       auto_req;
      logic       edge_det;
      logic       burst;
      logic       te;
      logic       ie;
      logic       de;
   } chan_ctrl_t;

   typedef enum logic [5:0] {
      ST_IDLE   = 6'h01,
      ST_WAIT_A = 6'h02,
      ST_WAIT_B = 6'h04,
      ST_READ   = 6'h08,
      ST_WRITE  = 6'h10,
      ST_GAP    = 6'h20
   } seq_state_t;

endpackage : dma_end_pkg

// >>> verilog/dma_req_end.sv
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
module dma_req_end #(
   parameter int NUM_CH     = 4,
   parameter int CNT_W      = 24,
   parameter int AXI_ADDR_W = 8
) (
   input  wire logic                  ref_clk,
   input  wire logic                  rst_b,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   output logic [1:0]                 s_axi_bresp,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   input  wire logic                  transfer_request_pin_b,
   input  wire logic                  nmi_pin_b,
   output logic                       bus_clock_output,
   output logic                       transfer_ack_pin_b,
   output logic                       read_strobe_b,
   output logic                       write_strobe_b,
   output logic [31:0]                mem_addr,
   output logic                       bus_hold,
   output logic                       transfer_end_interrupt
);
   localparam int DW = dma_end_pkg::DATA_W;
   localparam int CW = dma_end_pkg::CTRL_W;

   if (NUM_CH < 3 || NUM_CH > 4 || CNT_W < 3 || CNT_W > 32 || AXI_ADDR_W < 8) begin : bad_cfg
      $error("dma_req_end: unsupported parameter values");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // reset release, bus clock, pin synchronisers
   logic rst_q1_r, rst_sync_b_r, bus_clk_r, tick;
   logic req_s1_r, req_s2_r, req_s3_r, req_lvl_r, req_edge_r, req_fall;
   logic nmi_s1_r, nmi_s2_r, nmi_s3_r, nmi_lvl_r, nmi_fall;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_q1_r     <= 1'b0;
         rst_sync_b_r <= 1'b0;
      end else begin
         rst_q1_r     <= 1'b1;
         rst_sync_b_r <= rst_q1_r;
      end
   end

   // bus clock falls at every edge where it is high: that edge is a sampling point
   always_ff @(posedge ref_clk or negedge rst_sync_b_r) begin
      if (!rst_sync_b_r) bus_clk_r <= 1'b0;
      else bus_clk_r <= ~bus_clk_r;
   end
   assign tick             = bus_clk_r;
   assign bus_clock_output = bus_clk_r;

   assign req_fall = req_lvl_r && (req_s2_r == req_s3_r) && !req_s3_r;
   assign nmi_fall = nmi_lvl_r && (nmi_s2_r == nmi_s3_r) && !nmi_s3_r;

   always_ff @(posedge ref_clk or negedge rst_sync_b_r) begin
      if (!rst_sync_b_r) begin
         {req_s1_r, req_s2_r, req_s3_r, req_lvl_r} <= 4'hf;
         {nmi_s1_r, nmi_s2_r, nmi_s3_r, nmi_lvl_r} <= 4'hf;
      end else begin
         req_s1_r <= transfer_request_pin_b;
         req_s2_r <= req_s1_r;
         req_s3_r <= req_s2_r;
         if (req_s2_r == req_s3_r) req_lvl_r <= req_s3_r;
         nmi_s1_r <= nmi_pin_b;
         nmi_s2_r <= nmi_s1_r;
         nmi_s3_r <= nmi_s2_r;
         if (nmi_s2_r == nmi_s3_r) nmi_lvl_r <= nmi_s3_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // functions
   function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) r[b*8 +: 8] = d[b*8 +: 8];
      end
      return r;
   endfunction : wmerge

   function automatic logic addr_ok(input logic [AXI_ADDR_W-1:0] a);
      logic hi_zero;
      hi_zero = (a >> 8) == '0;
      if (!hi_zero) return 1'b0;
      else if (a[7:0] == dma_end_pkg::OPR_OFF) return 1'b1;
      else if (a[7:6] == 2'h0 && int'(a[5:4]) < NUM_CH && a[1:0] == 2'h0) return 1'b1;
      else return 1'b0;
   endfunction : addr_ok

   function automatic logic [31:0] size_step(input logic [1:0] sz);
      if (sz == dma_end_pkg::SIZE_BYTE) return dma_end_pkg::STEP_BYTE;
      else if (sz == dma_end_pkg::SIZE_HALF) return dma_end_pkg::STEP_HALF;
      else return dma_end_pkg::STEP_WORD;
   endfunction : size_step

   ////////////////////////////////////////////////////////////////////////////////
   // state
   logic [31:0]             src_work_r [NUM_CH];
   logic [31:0]             src_prog_r [NUM_CH];
   logic [31:0]             dst_r      [NUM_CH];
   logic [CNT_W-1:0]        cnt_r      [NUM_CH];
   dma_end_pkg::chan_ctrl_t ctrl_r     [NUM_CH];
   logic                    dme_r, nmi_abort_flag_r;
   logic [1:0]              rl_cnt_r;
   dma_end_pkg::seq_state_t st_r, st_nxt;
   logic [1:0]              cur_r, pick;
   logic                    ahead_r, ahead_nxt, take_edge;
   logic                    aw_hold_r, w_hold_r, wr_go, done, last, any_elig;
   logic [AXI_ADDR_W-1:0]   awaddr_r;
   logic [31:0]             wdata_r;
   logic [3:0]              wstrb_r;
   logic [1:0]              wch;
   logic [7:0]              woff;
   dma_end_pkg::chan_ctrl_t cc;
   logic                    stop, hit, req_ok, burst_edge, elig_cur;

   ////////////////////////////////////////////////////////////////////////////////
   // request sampling and transfer sequencing
   assign cc         = ctrl_r[cur_r];
   assign stop       = !dme_r || nmi_abort_flag_r || !cc.de;
   assign hit        = cc.auto_req || (cc.edge_det ? req_edge_r : !req_lvl_r);
   assign burst_edge = cc.burst && cc.edge_det && !cc.auto_req;
   assign req_ok     = !stop && (hit || burst_edge);
   assign elig_cur   = cc.de && !cc.te && cnt_r[cur_r] != '0 && dme_r && !nmi_abort_flag_r;
   assign done       = tick && st_r == dma_end_pkg::ST_WRITE;
   assign last       = cnt_r[cur_r] == CNT_W'(1);

   always_comb begin
      pick     = 2'h0;
      any_elig = 1'b0;
      for (int i = NUM_CH - 1; i >= 0; i--) begin
         if (ctrl_r[i].de && !ctrl_r[i].te && cnt_r[i] != '0) begin
            pick     = 2'(i);
            any_elig = 1'b1;
         end
      end
   end

   always_comb begin
      st_nxt    = st_r;
      ahead_nxt = ahead_r;
      take_edge = 1'b0;
      case (st_r)
         dma_end_pkg::ST_IDLE: begin
            if (elig_cur && hit && !stop) begin
               st_nxt    = dma_end_pkg::ST_WAIT_A;
               ahead_nxt = 1'b0;
               take_edge = 1'b1;
            end
         end
         dma_end_pkg::ST_WAIT_A: st_nxt = dma_end_pkg::ST_WAIT_B;
         dma_end_pkg::ST_WAIT_B: begin
            st_nxt    = dma_end_pkg::ST_READ;
            ahead_nxt = req_ok;
            take_edge = 1'b1;
         end
         dma_end_pkg::ST_READ, dma_end_pkg::ST_WRITE: begin
            if (!ahead_r) begin
               ahead_nxt = req_ok;
               take_edge = 1'b1;
            end
            if (st_r == dma_end_pkg::ST_READ) begin
               st_nxt = dma_end_pkg::ST_WRITE;
            end else if (last) begin
               st_nxt    = dma_end_pkg::ST_IDLE;
               ahead_nxt = 1'b0;
            end else begin
               st_nxt = dma_end_pkg::ST_GAP;
            end
         end
         dma_end_pkg::ST_GAP: begin
            if (ahead_r) begin
               st_nxt    = dma_end_pkg::ST_READ;
               ahead_nxt = req_ok;
               take_edge = 1'b1;
            end else if (req_ok) begin
               st_nxt    = dma_end_pkg::ST_WAIT_A;
               take_edge = 1'b1;
            end else begin
               st_nxt = dma_end_pkg::ST_IDLE;
            end
         end
         default: st_nxt = dma_end_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_sync_b_r) begin
      if (!rst_sync_b_r) begin
         st_r    <= dma_end_pkg::ST_IDLE;
         cur_r   <= 2'h0;
         ahead_r <= 1'b0;
      end else if (tick) begin
         st_r    <= st_nxt;
         ahead_r <= ahead_nxt;
         if (st_r == dma_end_pkg::ST_IDLE && st_nxt == dma_end_pkg::ST_IDLE && any_elig) cur_r <= pick;
      end
   end

   // a falling request edge is held until a sampling point consumes it, or drops it while idle with the current channel not eligible
   always_ff @(posedge ref_clk or negedge rst_sync_b_r) begin
      if (!rst_sync_b_r) req_edge_r <= 1'b0;
      else if (req_fall) req_edge_r <= 1'b1;
      else if (tick && (take_edge || (st_r == dma_end_pkg::ST_IDLE && !elig_cur))) req_edge_r <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // pin outputs, registered at the bus clock fall; the interrupt output at every ref_clk edge
   always_ff @(posedge ref_clk or negedge rst_sync_b_r) begin
      if (!rst_sync_b_r) begin
         read_strobe_b      <= 1'b1;
         write_strobe_b     <= 1'b1;
         transfer_ack_pin_b <= 1'b1;
         bus_hold           <= 1'b0;
         mem_addr           <= '0;
      end else if (tick) begin
         read_strobe_b      <= st_nxt != dma_end_pkg::ST_READ;
         write_strobe_b     <= st_nxt != dma_end_pkg::ST_WRITE;
         transfer_ack_pin_b <= !((st_nxt == dma_end_pkg::ST_READ && !cc.ack_wr) ||
                                 (st_nxt == dma_end_pkg::ST_WRITE && cc.ack_wr));
         // cycle steal gives the bus back in the gap, burst keeps it
         bus_hold <= st_nxt == dma_end_pkg::ST_READ || st_nxt == dma_end_pkg::ST_WRITE ||
                     (st_nxt == dma_end_pkg::ST_GAP && cc.burst);
         mem_addr <= (st_nxt == dma_end_pkg::ST_WRITE) ? dst_r[cur_r] : src_work_r[cur_r];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_sync_b_r) begin
      if (!rst_sync_b_r) transfer_end_interrupt <= 1'b0;
      else begin
         transfer_end_interrupt <= 1'b0;
         for (int i = 0; i < NUM_CH; i++) begin
            if (ctrl_r[i].te && ctrl_r[i].ie) transfer_end_interrupt <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // modulo-four reload counter of channel 2
   always_ff @(posedge ref_clk or negedge rst_sync_b_r) begin
      if (!rst_sync_b_r) rl_cnt_r <= 2'h0;
      else if (!dme_r || nmi_abort_flag_r || !ctrl_r[dma_end_pkg::RELOAD_CH].de ||
               ctrl_r[dma_end_pkg::RELOAD_CH].te) rl_cnt_r <= 2'h0;
      else if (done && cur_r == 2'(dma_end_pkg::RELOAD_CH) && cc.reload) rl_cnt_r <= rl_cnt_r + 2'h1;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write path
   assign wch  = awaddr_r[5:4];
   assign woff = {4'h0, awaddr_r[3:0]};
   assign wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid;

   always_ff @(posedge ref_clk or negedge rst_sync_b_r) begin
      if (!rst_sync_b_r) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         aw_hold_r     <= 1'b0;
         w_hold_r      <= 1'b0;
         awaddr_r      <= '0;
         wdata_r       <= '0;
         wstrb_r       <= 4'h0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= dma_end_pkg::RESP_OKAY;
      end else begin
         s_axi_awready <= s_axi_awvalid && !s_axi_awready && !aw_hold_r && !s_axi_bvalid;
         s_axi_wready  <= s_axi_wvalid && !s_axi_wready && !w_hold_r && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_r <= 1'b1;
            awaddr_r  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_hold_r    <= 1'b0;
            w_hold_r     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= addr_ok(awaddr_r) ? dma_end_pkg::RESP_OKAY : dma_end_pkg::RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // global enable and abort flag; the abort input wins over a clearing write
   always_ff @(posedge ref_clk or negedge rst_sync_b_r) begin
      if (!rst_sync_b_r) begin
         dme_r  <= 1'b0;
         nmi_abort_flag_r <= 1'b0;
      end else begin
         if (wr_go && addr_ok(awaddr_r) && awaddr_r[7:0] == dma_end_pkg::OPR_OFF && wstrb_r[0]) begin
            dme_r <= wdata_r[dma_end_pkg::DME_BIT];
            if (!wdata_r[dma_end_pkg::NMI_ABORT_FLAG_BIT]) nmi_abort_flag_r <= 1'b0;
         end
         if (nmi_fall) nmi_abort_flag_r <= 1'b1;
      end
   end

   // channel registers: software write beats the engine, except end flag set wins
   always_ff @(posedge ref_clk or negedge rst_sync_b_r) begin
      if (!rst_sync_b_r) begin
         for (int i = 0; i < NUM_CH; i++) begin
            src_work_r[i] <= '0;
            src_prog_r[i] <= '0;
            dst_r[i]      <= '0;
            cnt_r[i]      <= '0;
            ctrl_r[i]     <= '0;
         end
      end else begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (done && cur_r == 2'(i)) begin
               cnt_r[i] <= cnt_r[i] - CNT_W'(1);
               if (i == dma_end_pkg::RELOAD_CH && ctrl_r[i].reload && rl_cnt_r == dma_end_pkg::RELOAD_LAST)
                  src_work_r[i] <= src_prog_r[i];
               else src_work_r[i] <= src_work_r[i] + size_step(ctrl_r[i].size);
            end
            if (wr_go && addr_ok(awaddr_r) && awaddr_r[7:6] == 2'h0 && wch == 2'(i)) begin
               if (woff == dma_end_pkg::SRC_OFF) begin
                  src_work_r[i] <= wmerge(src_work_r[i], wdata_r, wstrb_r);
                  src_prog_r[i] <= wmerge(src_work_r[i], wdata_r, wstrb_r);
               end else if (woff == dma_end_pkg::DST_OFF) begin
                  dst_r[i] <= wmerge(dst_r[i], wdata_r, wstrb_r);
               end else if (woff == dma_end_pkg::CNT_OFF) begin
                  cnt_r[i] <= CNT_W'(wmerge(DW'(cnt_r[i]), wdata_r, wstrb_r));
               end else if (woff == dma_end_pkg::CTRL_OFF) begin
                  // end flag may only be cleared by writing 0
                  ctrl_r[i] <= dma_end_pkg::chan_ctrl_t'(CW'(wmerge(DW'(ctrl_r[i]), wdata_r, wstrb_r)));
                  ctrl_r[i].te <= ctrl_r[i].te && !(wstrb_r[0] && !wdata_r[2]);
               end
            end
            if (done && cur_r == 2'(i) && last) ctrl_r[i].te <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read path
   always_ff @(posedge ref_clk or negedge rst_sync_b_r) begin
      if (!rst_sync_b_r) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= dma_end_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= addr_ok(s_axi_araddr) ? dma_end_pkg::RESP_OKAY : dma_end_pkg::RESP_SLVERR;
            if (!addr_ok(s_axi_araddr)) s_axi_rdata <= '0;
            else if (s_axi_araddr[7:0] == dma_end_pkg::OPR_OFF) s_axi_rdata <= {30'h0, nmi_abort_flag_r, dme_r};
            else if (s_axi_araddr[3:0] == dma_end_pkg::SRC_OFF[3:0]) s_axi_rdata <= src_work_r[s_axi_araddr[5:4]];
            else if (s_axi_araddr[3:0] == dma_end_pkg::DST_OFF[3:0]) s_axi_rdata <= dst_r[s_axi_araddr[5:4]];
            else if (s_axi_araddr[3:0] == dma_end_pkg::CNT_OFF[3:0]) s_axi_rdata <= DW'(cnt_r[s_axi_araddr[5:4]]);
            else s_axi_rdata <= DW'(ctrl_r[s_axi_araddr[5:4]]);
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking dcb @(posedge ref_clk); endclocking
   default disable iff (!rst_sync_b_r);

   ack_with_strobe_a: assert property (!transfer_ack_pin_b |->
      (!read_strobe_b && !cc.ack_wr) || (!write_strobe_b && cc.ack_wr)) else $error("ack without its strobe");
   first_start_delay_a: assert property ((tick && st_r == dma_end_pkg::ST_IDLE &&
      st_nxt == dma_end_pkg::ST_WAIT_A) |=> (st_r != dma_end_pkg::ST_READ)[*4] ##1 (st_r == dma_end_pkg::ST_READ))
      else $error("first access not three bus cycles after sample");
   write_follows_read_a: assert property ((tick && st_r == dma_end_pkg::ST_READ) |=>
      st_r == dma_end_pkg::ST_WRITE [*2]) else $error("read not followed by write");
   count_step_a: assert property ((tick && st_r == dma_end_pkg::ST_WRITE && !wr_go) |=>
      cnt_r[cur_r] == $past(cnt_r[cur_r]) - CNT_W'(1)) else $error("count not decremented");
   end_flag_set_a: assert property ((done && last) |=>
      ctrl_r[cur_r].te && st_r == dma_end_pkg::ST_IDLE) else $error("end flag missing at count zero");
   no_flag_halt_a: assert property ((tick && st_r == dma_end_pkg::ST_WRITE && !last) |=>
      !$rose(ctrl_r[cur_r].te)) else $error("end flag set without count zero");
   abort_flag_a: assert property (nmi_fall |=> nmi_abort_flag_r) else $error("abort flag not set");
   abort_release_a: assert property ($rose(nmi_abort_flag_r) |-> ##[0:16] !bus_hold)
      else $error("bus not released after abort");
   reload_restore_a: assert property ((done && cur_r == 2'(dma_end_pkg::RELOAD_CH) && cc.reload &&
      rl_cnt_r == dma_end_pkg::RELOAD_LAST && !wr_go) |=> src_work_r[cur_r] == src_prog_r[cur_r])
      else $error("source not reloaded");
   reload_clear_a: assert property ((!dme_r || nmi_abort_flag_r || !ctrl_r[dma_end_pkg::RELOAD_CH].de) |=>
      rl_cnt_r == 2'h0) else $error("reload counter not cleared");
   stop_no_accept_a: assert property ((tick && stop && !ahead_r && st_r == dma_end_pkg::ST_GAP) |=>
      st_r == dma_end_pkg::ST_IDLE) else $error("request accepted after stop");
   edge_burst_run_a: assert property ((tick && burst_edge && !stop && !last &&
      st_r == dma_end_pkg::ST_WRITE) |=> ahead_r) else $error("edge burst did not continue");

   steal_cycle_c: cover property ((tick && st_r == dma_end_pkg::ST_GAP && !cc.burst) ##[1:4] !read_strobe_b);
   edge_burst_c: cover property (tick && burst_edge && st_r == dma_end_pkg::ST_GAP && ahead_r);
   reload_c: cover property (done && cc.reload && rl_cnt_r == dma_end_pkg::RELOAD_LAST);
   abort_c: cover property ($rose(nmi_abort_flag_r) && bus_hold);

endmodule : dma_req_end

// >>> sim/dma_req_peer.sv
`timescale 1ns/10ps
module dma_req_peer (
   input  wire logic ref_clk,
   input  wire logic go,
   input  wire logic transfer_ack_pin_b,
   output logic      transfer_request_pin_b
);
   int served = 0;
   // counts ack cycles, two to one transfer; restarts while go is low
   always_ff @(posedge ref_clk) begin
      if (!go) served <= 0;
      else if (transfer_ack_pin_b === 1'b0) served <= served + 1;
   end
   // level request held until four transfers were served
   assign transfer_request_pin_b = !(go && served < 8);
endmodule : dma_req_peer

// >>> sim/tb_dma_req_end.sv
`timescale 1ns/10ps
module tb_dma_req_end;
   logic ref_clk, rst_b, awv, wv, bq, arv, rq, go, on_wr, nmi_b;
   logic [7:0] awa, ara;
   logic [31:0] wd, d;
   logic [1:0] r;
   wire logic awr, wr_r, bv, arr, rv, req_b, bclk, ack_b, rds_b, wrs_b, hold, irq;
   wire logic [1:0] br, rr;
   wire logic [31:0] rdat, maddr;
   int err_total = 0, checks_done = 0, bad_ack = 0, acks = 0;
   dma_req_end DUT (.ref_clk(ref_clk), .rst_b(rst_b), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
      .s_axi_bvalid(bv), .s_axi_bready(bq), .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rq), .s_axi_rdata(rdat), .s_axi_rresp(rr),
      .transfer_request_pin_b(req_b), .nmi_pin_b(nmi_b), .bus_clock_output(bclk),
      .transfer_ack_pin_b(ack_b), .read_strobe_b(rds_b), .write_strobe_b(wrs_b), .mem_addr(maddr),
      .bus_hold(hold), .transfer_end_interrupt(irq));
   dma_req_peer peer (.ref_clk(ref_clk), .go(go), .transfer_ack_pin_b(ack_b), .transfer_request_pin_b(req_b));
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) if (rst_b) begin
      if (ack_b !== (on_wr ? wrs_b : rds_b)) bad_ack++;
      if (ack_b === 1'b0) acks++;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      $display("mismatches %0d comparisons %0d", err_total, checks_done);
      if (err_total == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : give_verdict
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      checks_done++;
      if (s !== e) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic bound(input int n);
      if (n >= 3000) begin
         err_total++;
         give_verdict();
      end
   endtask : bound
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      int n;
      n = 0;
      awa <= a; wd <= v; awv <= 1'b1; wv <= 1'b1; bq <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
         if (awr === 1'b1) awv <= 1'b0;
         if (wr_r === 1'b1) wv <= 1'b0;
      end while (bv !== 1'b1 && n < 3000);
      bq <= 1'b0;
      bound(n);
      @(posedge ref_clk);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      int n;
      n = 0;
      ara <= a; arv <= 1'b1; rq <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
         if (arr === 1'b1) arv <= 1'b0;
      end while (rv !== 1'b1 && n < 3000);
      d = rdat; r = rr; rq <= 1'b0;
      bound(n);
      @(posedge ref_clk);
   endtask : rd
   task automatic wait_irq();
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 3000) begin
         @(posedge ref_clk);
         n++;
      end
      bound(n);
   endtask : wait_irq
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      rst_b = 1'b0; awv = 1'b0; wv = 1'b0; bq = 1'b0; arv = 1'b0; rq = 1'b0; go = 1'b0; on_wr = 1'b0;
      awa = 8'h00; ara = 8'h00; wd = 32'h0; nmi_b = 1'b1;
      repeat (4) @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge ref_clk);
      // channel 0: external level request, cycle steal, word size, four transfers
      wr(dma_end_pkg::SRC_OFF, 32'h0000_1000);
      wr(dma_end_pkg::DST_OFF, 32'h0000_2000);
      wr(dma_end_pkg::CNT_OFF, 32'h0000_0004);
      wr(dma_end_pkg::CTRL_OFF, 32'h0000_0203);
      go <= 1'b1;
      wr(dma_end_pkg::OPR_OFF, 32'h0000_0001);
      wait_irq();
      rd(dma_end_pkg::CNT_OFF); chk("count0", 32'h0, d);
      rd(dma_end_pkg::SRC_OFF); chk("src0", 32'h0000_1010, d);
      rd(dma_end_pkg::CTRL_OFF); chk("ctrl0", 32'h0000_0207, d);
      chk("ack_read", 32'h0, bad_ack);
      chk("ack_cycles", 32'h8, acks);
      wr(dma_end_pkg::CTRL_OFF, 32'h0000_0202);
      // channel 1: external edge burst, word size, abort in mid-run, then restart
      go <= 1'b0;
      acks = 0;
      wr(8'h10 + dma_end_pkg::SRC_OFF, 32'h0000_4000);
      wr(8'h10 + dma_end_pkg::CNT_OFF, 32'h0000_0010);
      wr(8'h10 + dma_end_pkg::CTRL_OFF, 32'h0000_021b);
      go <= 1'b1;
      repeat (40) @(posedge ref_clk);
      nmi_b <= 1'b0;
      repeat (30) @(posedge ref_clk);
      chk("abort_hold", 32'h0, {31'h0, hold});
      nmi_b <= 1'b1;
      rd(dma_end_pkg::OPR_OFF); chk("abort_flag", 32'h3, d);
      rd(8'h10 + dma_end_pkg::CTRL_OFF); chk("abort_ctrl", 32'h0000_021b, d);
      rd(8'h10 + dma_end_pkg::CNT_OFF); chk("abort_cnt", 32'h1, {31'h0, d != 32'h0 && d < 32'h10});
      go <= 1'b0;
      wr(dma_end_pkg::OPR_OFF, 32'h0000_0001);
      go <= 1'b1;
      wait_irq();
      rd(8'h10 + dma_end_pkg::SRC_OFF); chk("src1", 32'h0000_4040, d);
      rd(8'h10 + dma_end_pkg::CNT_OFF); chk("count1", 32'h0, d);
      chk("ack_cycles1", 32'h20, acks);
      wr(8'h10 + dma_end_pkg::CTRL_OFF, 32'h0000_021a);
      // channel 2: auto burst, halfword, reload, ack on write, eight transfers
      @(posedge ref_clk);
      on_wr = 1'b1; acks = 0;
      wr(8'h20 + dma_end_pkg::SRC_OFF, 32'h0000_3000);
      wr(8'h20 + dma_end_pkg::DST_OFF, 32'h0000_5000);
      wr(8'h20 + dma_end_pkg::CNT_OFF, 32'h0000_0008);
      wr(8'h20 + dma_end_pkg::CTRL_OFF, 32'h0000_01eb);
      wait_irq();
      rd(8'h20 + dma_end_pkg::SRC_OFF); chk("src2_reload", 32'h0000_3000, d);
      rd(8'h20 + dma_end_pkg::CTRL_OFF); chk("ctrl2", 32'h0000_01ef, d);
      chk("ack_write", 32'h0, bad_ack);
      chk("ack_cycles2", 32'h10, acks);
      rd(8'h80); chk("unmapped", {30'h0, dma_end_pkg::RESP_SLVERR}, {30'h0, r});
      give_verdict();
   end
endmodule : tb_dma_req_end
